// ### src/picmd_pkg.sv
// Constants and types shared by the printer command interpreter files
`default_nettype none
package picmd_pkg;
	localparam int unsigned PICMD_BYTE_W = 8;
	localparam int unsigned PICMD_FIFO_DEPTH = 8;
	localparam logic [7:0] PICMD_ESC = 8'h1b;
	localparam logic [7:0] PICMD_GATE_CODE = 8'h3d;
	localparam logic [7:0] PICMD_ALIGN_CODE = 8'h61;
	localparam logic [7:0] PICMD_FULL_CUT_CODE = 8'h69;
	localparam logic [7:0] PICMD_PART_CUT_CODE = 8'h6d;
	localparam int unsigned PICMD_SEL_BIT = 0;
	localparam logic PICMD_SEL_RESET = 1'b1;
	localparam logic [1:0] PICMD_ALIGN_LEFT = 2'h0;
	localparam logic [1:0] PICMD_ALIGN_CENTER = 2'h1;
	localparam logic [1:0] PICMD_ALIGN_RIGHT = 2'h2;
	localparam logic [7:0] PICMD_ALIGN_MAX = 8'h02;

	typedef enum logic [4:0] {
		PICMD_IDLE = 5'h01,
		PICMD_GOT_ESC = 5'h02,
		PICMD_GATE_ARG = 5'h04,
		PICMD_ALIGN_ARG = 5'h08,
		PICMD_PASS = 5'h10
	} picmd_state_type;
endpackage : picmd_pkg
`default_nettype wire

// ### src/picmd_top.sv
// Receive FIFO and escape-sequence interpreter for gating, alignment and cutting
`default_nettype none

module picmd_fifo
	import picmd_pkg::*;
#(
	parameter int unsigned WIDTH = PICMD_BYTE_W,
	parameter int unsigned DEPTH = PICMD_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr;
		logic [PW-1:0] rd;
		logic [CW-1:0] cnt;
		logic full;
		logic empty;
	} picmd_fifo_type;

	picmd_fifo_type s;
	picmd_fifo_type next_s;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		bump = (p == PTR_LAST) ? '0 : p + PW'(1);
	endfunction : bump

	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop = 1'b0;
		next_s = s;
		push = ce && in_valid && !s.full;
		pop = ce && out_ready && !s.empty;
		if (push) begin
			next_s.mem[s.wr] = in_data;
			next_s.wr = bump(s.wr);
		end
		if (pop) begin
			next_s.rd = bump(s.rd);
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + CNT_ONE;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - CNT_ONE;
		end
		next_s.full = (next_s.cnt == CNT_FULL);
		next_s.empty = (next_s.cnt == '0);
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			s <= '0;
			s.empty <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign in_ready = !s.full;
	assign out_valid = !s.empty;
	assign out_data = s.mem[s.rd];
endmodule : picmd_fifo

// Functional notes
// - Gate command is ESC, 3D, then any parameter byte; it selects input acceptance.
// - Only parameter bit 0 counts: 1 selects, 0 deselects; other bits ignored.
// - Deselected: drop every byte except a gate command that reselects.
// - Busy toward host still follows printing activity while deselected.
// - After reset the printer is selected.
// - Alignment command ESC, 61, n: 0 left, 1 centre, 2 right.
// - Alignment and cut commands act only at the beginning of a line.
// - After reset alignment is left.
// - ESC, 69 fires a full cut.
// - ESC, 6D fires a partial cut when the cutter option is fitted.
module picmd_top
	import picmd_pkg::*;
#(
	parameter int unsigned FIFO_DEPTH = PICMD_FIFO_DEPTH
) (
	input wire logic CLOCK,
	input wire logic SRST,
	input wire logic CE,
	input wire logic [7:0] RX_DATA,
	input wire logic RX_VALID,
	output logic RX_READY,
	input wire logic LINE_START,
	input wire logic CUTTER_FITTED,
	input wire logic ENGINE_BUSY,
	output logic [7:0] PRINT_DATA,
	output logic PRINT_VALID,
	input wire logic PRINT_READY,
	output logic [1:0] ALIGN,
	output logic SELECTED,
	output logic FULL_CUT,
	output logic PARTIAL_CUT,
	output logic BUSY
);
	typedef struct packed {
		picmd_state_type state;
		logic selected;
		logic [1:0] align;
		logic [7:0] print_data;
		logic print_valid;
		logic full_cut;
		logic part_cut;
		logic busy;
	} picmd_top_type;

	picmd_top_type s;
	picmd_top_type next_s;
	logic [7:0] f_data;
	logic f_valid;
	logic f_pop;
	logic f_in_ready;
	logic out_free;
	logic step;
	logic emit;

	assign out_free = !s.print_valid || PRINT_READY;
	assign step = CE && f_valid && out_free;

	picmd_fifo #(.WIDTH(PICMD_BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(CLOCK),
		.srst(SRST),
		.ce(CE),
		.in_data(RX_DATA),
		.in_valid(RX_VALID),
		.in_ready(f_in_ready),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(f_pop)
	);

	always_comb begin
		next_s = s;
		emit = 1'b0;
		f_pop = step;
		if (CE) begin
			next_s.busy = ENGINE_BUSY || !f_in_ready;
			next_s.full_cut = 1'b0;
			next_s.part_cut = 1'b0;
			if (PRINT_READY) begin
				next_s.print_valid = 1'b0;
			end
		end
		if (step) begin
			case (s.state)
				PICMD_IDLE: begin
					if (f_data == PICMD_ESC) begin
						next_s.state = PICMD_GOT_ESC;
					end else if (s.selected) begin
						emit = 1'b1;
						next_s.print_data = f_data;
					end
				end
				PICMD_GOT_ESC: begin
					next_s.state = PICMD_IDLE;
					if (f_data == PICMD_GATE_CODE) begin
						next_s.state = PICMD_GATE_ARG;
					end else if (!s.selected) begin
						next_s.state = PICMD_IDLE;
					end else if (f_data == PICMD_ALIGN_CODE) begin
						next_s.state = PICMD_ALIGN_ARG;
					end else if (f_data == PICMD_FULL_CUT_CODE) begin
						next_s.full_cut = LINE_START;
					end else if (f_data == PICMD_PART_CUT_CODE) begin
						next_s.part_cut = LINE_START && CUTTER_FITTED;
					end else begin
						// Foreign escape: forward ESC now, the byte next step
						f_pop = 1'b0;
						emit = 1'b1;
						next_s.print_data = PICMD_ESC;
						next_s.state = PICMD_PASS;
					end
				end
				PICMD_GATE_ARG: begin
					next_s.selected = f_data[PICMD_SEL_BIT];
					next_s.state = PICMD_IDLE;
				end
				PICMD_ALIGN_ARG: begin
					if (LINE_START && f_data <= PICMD_ALIGN_MAX) begin
						next_s.align = f_data[1:0];
					end
					next_s.state = PICMD_IDLE;
				end
				PICMD_PASS: begin
					emit = 1'b1;
					next_s.print_data = f_data;
					next_s.state = PICMD_IDLE;
				end
				default: begin
					next_s.state = PICMD_IDLE;
				end
			endcase
		end
		if (emit) begin
			next_s.print_valid = 1'b1;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SRST) begin
			s <= '0;
			s.state <= PICMD_IDLE;
			s.selected <= PICMD_SEL_RESET;
			s.align <= PICMD_ALIGN_LEFT;
		end else if (CE) begin
			s <= next_s;
		end
	end

	assign RX_READY = f_in_ready;
	assign PRINT_DATA = s.print_data;
	assign PRINT_VALID = s.print_valid;
	assign ALIGN = s.align;
	assign SELECTED = s.selected;
	assign FULL_CUT = s.full_cut;
	assign PARTIAL_CUT = s.part_cut;
	assign BUSY = s.busy;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SRST);

	gate_select_a: assert property ((s.state == PICMD_GATE_ARG) && step |=>
		SELECTED == $past(f_data[0]))
		else $error("gate parameter bit 0 not applied");
	deselect_drop_a: assert property (!s.selected && step |-> !emit)
		else $error("byte forwarded while deselected");
	busy_follow_a: assert property (CE |=> BUSY == $past(ENGINE_BUSY || !f_in_ready))
		else $error("busy does not follow engine activity");
	reset_init_a: assert property ($past(SRST) |-> SELECTED && ALIGN == PICMD_ALIGN_LEFT)
		else $error("wrong state after reset");
	align_take_a: assert property ((s.state == PICMD_ALIGN_ARG) && step && LINE_START
		&& f_data <= PICMD_ALIGN_MAX |=> ALIGN == $past(f_data[1:0]))
		else $error("alignment not taken");
	align_ignore_a: assert property ((s.state == PICMD_ALIGN_ARG) && step
		&& (!LINE_START || f_data > PICMD_ALIGN_MAX) |=> $stable(ALIGN))
		else $error("alignment changed when it should be ignored");
	full_cut_a: assert property ((s.state == PICMD_GOT_ESC) && step && s.selected
		&& f_data == PICMD_FULL_CUT_CODE && LINE_START |=> FULL_CUT)
		else $error("full cut not fired");
	part_cut_a: assert property ((s.state == PICMD_GOT_ESC) && step && s.selected
		&& f_data == PICMD_PART_CUT_CODE && LINE_START && CUTTER_FITTED |=> PARTIAL_CUT)
		else $error("partial cut not fired");
	cut_line_a: assert property ($rose(FULL_CUT) || $rose(PARTIAL_CUT) |->
		$past(LINE_START))
		else $error("cut fired away from line start");
endmodule : picmd_top
`default_nettype wire

// ### tb/picmd_host.sv
// Host model that sends command and print bytes over the valid/ready input
`default_nettype none
module picmd_host (
	input wire logic clock,
	input wire logic ready,
	output logic [7:0] data,
	output logic valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		valid = 1'b0;
		data = 8'h00;
	end
	// Holds each byte until taken; after release the data line shows its inverse
	// LINE_START is driven by the bench, not by this host; t_cut clears it to check that cuts are then ignored.
	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) begin
			@(negedge clock);
			valid = 1'b1;
			data = b[i];
			while (ready !== 1'b1) @(negedge clock);
			@(posedge clock);
		end
		@(negedge clock);
		valid = 1'b0;
		data = ~data;
	endtask : send
endmodule : picmd_host
`default_nettype wire

// ### tb/picmd_top_tb.sv
// Self-checking bench for the command interpreter
`default_nettype none
module picmd_top_tb
	import picmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK = 1'b0, SRST = 1'b1, LINE_START = 1'b1, CUTTER_FITTED = 1'b1;
	logic ENGINE_BUSY = 1'b0, PRINT_READY = 1'b1, RX_VALID, RX_READY, PRINT_VALID;
	logic SELECTED, FULL_CUT, PARTIAL_CUT, BUSY;
	logic CE = 1'b1;
	logic [7:0] RX_DATA, PRINT_DATA, nfull = 8'h00, npart = 8'h00;
	logic [1:0] ALIGN;
	logic [7:0] got[$], q[$];
	int mismatches = 0, n_compared = 0;
	picmd_host host_u (.clock(CLOCK), .ready(RX_READY), .data(RX_DATA), .valid(RX_VALID));
	picmd_top dut_u (.CLOCK(CLOCK), .SRST(SRST), .CE(CE), .RX_DATA(RX_DATA),
		.RX_VALID(RX_VALID), .RX_READY(RX_READY), .LINE_START(LINE_START),
		.CUTTER_FITTED(CUTTER_FITTED), .ENGINE_BUSY(ENGINE_BUSY), .PRINT_DATA(PRINT_DATA),
		.PRINT_VALID(PRINT_VALID), .PRINT_READY(PRINT_READY), .ALIGN(ALIGN),
		.SELECTED(SELECTED), .FULL_CUT(FULL_CUT), .PARTIAL_CUT(PARTIAL_CUT), .BUSY(BUSY));
	initial begin
		forever #5 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		if (PRINT_VALID === 1'b1 && PRINT_READY === 1'b1)
			got.push_back(PRINT_DATA);
		if (FULL_CUT === 1'b1)
			nfull <= nfull + 8'h01;
		if (PARTIAL_CUT === 1'b1)
			npart <= npart + 8'h01;
	end
	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
		n_compared++;
		if (act !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got %h expected %h", $time, act, exp);
		end
	endtask : chk
	task automatic settle();
		repeat (20) @(negedge CLOCK);
	endtask : settle
	task automatic t_reset();
		chk(ALIGN, 8'h00);
		chk(SELECTED, 8'h01);
		chk(FULL_CUT | PARTIAL_CUT, 8'h00);
		chk(RX_READY, 8'h01);
		chk(PRINT_VALID, 8'h00);
		chk(BUSY, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_rearm();
		host_u.send('{PICMD_ESC, PICMD_GATE_CODE, 8'h00});
		settle();
		chk(SELECTED, 8'h00);
		CE = 1'b0;
		ENGINE_BUSY = 1'b1;
		repeat (5) @(negedge CLOCK);
		chk(BUSY, 8'h00);
		CE = 1'b1;
		repeat (2) @(negedge CLOCK);
		chk(BUSY, 8'h01);
		ENGINE_BUSY = 1'b0;
		SRST = 1'b1;
		repeat (2) @(negedge CLOCK);
		SRST = 1'b0;
		t_reset();
		$display("test rearm done");
	endtask : t_rearm
	task automatic t_cut();
		host_u.send('{PICMD_ESC, PICMD_FULL_CUT_CODE});
		settle();
		chk(nfull, 8'h01);
		host_u.send('{PICMD_ESC, PICMD_PART_CUT_CODE});
		settle();
		chk(npart, 8'h01);
		LINE_START = 1'b0;
		host_u.send('{PICMD_ESC, PICMD_FULL_CUT_CODE, PICMD_ESC, PICMD_PART_CUT_CODE});
		settle();
		chk({nfull[3:0], npart[3:0]}, 8'h11);
		LINE_START = 1'b1;
		CUTTER_FITTED = 1'b0;
		host_u.send('{PICMD_ESC, PICMD_PART_CUT_CODE});
		settle();
		chk(npart, 8'h01);
		$display("test cut done");
	endtask : t_cut
	task automatic t_align();
		for (int n = 0; n < 4; n++) begin
			host_u.send('{PICMD_ESC, PICMD_ALIGN_CODE, 8'(n)});
			settle();
			chk(ALIGN, (n < 3) ? 8'(n) : 8'h02);
		end
		LINE_START = 1'b0;
		host_u.send('{PICMD_ESC, PICMD_ALIGN_CODE, 8'h00});
		settle();
		chk(ALIGN, 8'h02);
		LINE_START = 1'b1;
		$display("test align done");
	endtask : t_align
	task automatic t_gate();
		got.delete();
		host_u.send('{PICMD_ESC, PICMD_GATE_CODE, 8'hfe});
		settle();
		chk(SELECTED, 8'h00);
		ENGINE_BUSY = 1'b1;
		host_u.send('{8'h41, PICMD_ESC, PICMD_FULL_CUT_CODE});
		settle();
		chk(BUSY, 8'h01);
		chk(nfull, 8'h01);
		ENGINE_BUSY = 1'b0;
		host_u.send('{PICMD_ESC, PICMD_GATE_CODE, 8'h03, 8'h42, PICMD_ESC, 8'h41});
		settle();
		chk(SELECTED, 8'h01);
		chk(8'(got.size()), 8'h03);
		chk(got[0], 8'h42);
		chk(got[1], PICMD_ESC);
		chk(got[2], 8'h41);
		$display("test gate done");
	endtask : t_gate
	task automatic t_fifo();
		got.delete();
		q.delete();
		for (int i = 0; i < 10; i++)
			q.push_back(8'h30 + 8'(i));
		PRINT_READY = 1'b0;
		fork
			host_u.send(q);
		join_none
		repeat (30) @(negedge CLOCK);
		chk({RX_READY, BUSY}, 8'h01);
		PRINT_READY = 1'b1;
		repeat (40) @(negedge CLOCK);
		chk(8'(got.size()), 8'h0a);
		foreach (got[i])
			chk(got[i], 8'h30 + 8'(i));
		$display("test fifo done");
	endtask : t_fifo
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	initial begin
		#100us;
		mismatches++;
		results();
	end
	initial begin
		repeat (2) @(negedge CLOCK);
		SRST = 1'b0;
		t_reset();
		t_cut();
		t_align();
		t_rearm();
		t_gate();
		t_fifo();
		results();
	end
endmodule : picmd_top_tb
`default_nettype wire
